/* File: spc_pkg.sv */
// Shared constants for the SDRAM pin command interface block
package spc_pkg;

    // Array geometry
    localparam int BANK_W = 2;
    localparam int BANKS = 4;
    localparam int ROW_BITS = 12;
    localparam int COL_BITS = 8;
    localparam int DATA_W = 32;
    localparam int MASK_W = 4;
    localparam int BYTE_W = 8;

    // Mode register layout, taken from the address lines
    localparam int MODE_W = 12;
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_BT_BIT = 3;
    localparam int MODE_CL_LSB = 4;
    localparam int MODE_WBL_BIT = 9;
    localparam logic [MODE_W-1:0] MODE_RESET = 12'h030;
    localparam logic [2:0] BL_CODE_1 = 3'h0;
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [2:0] BL_CODE_FULL = 3'h7;
    localparam logic [2:0] CL_CODE_1 = 3'h1;
    localparam logic [2:0] CL_CODE_2 = 3'h2;

    // Address bit that turns a precharge into precharge-all
    localparam int PALL_BIT = 10;

    // Register bus map
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] REG_MODE_OFF = 8'h00;
    localparam logic [AXI_AW-1:0] REG_STATUS_OFF = 8'h04;
    localparam int ST_POWER_DOWN = 4;
    localparam int ST_FROZEN = 5;
    localparam int ST_BURST_ON = 6;
    localparam int ST_BURST_WR = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin commands, decoded from the strobes
    typedef enum logic [2:0] {
        CMD_MODE_LOAD,
        CMD_REFRESH,
        CMD_PRECHARGE,
        CMD_ACTIVATE,
        CMD_WRITE,
        CMD_READ,
        CMD_BURST_STOP,
        CMD_NOP
    } spc_cmd_type;

endpackage : spc_pkg

/* File: spc_array.sv */
// Flip-flop storage array with byte-blocked write and direct read
`timescale 1ns/10ps
module spc_array #(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 32,
    parameter int MASK_W = 4
) (
    input wire logic aclk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [MASK_W-1:0] wr_block,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);
    localparam int LANE_W = DATA_W / MASK_W;

    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [DATA_W-1:0] old_word;
    logic [DATA_W-1:0] next_word;

    assign old_word = mem[wr_addr];
    assign rd_data = mem[rd_addr];

    // Blocked lanes keep the stored byte
    for (genvar b = 0; b < MASK_W; b++) begin : g_lane
        assign next_word[b*LANE_W +: LANE_W] = wr_block[b] ?
            old_word[b*LANE_W +: LANE_W] : wr_data[b*LANE_W +: LANE_W];
    end

    always_ff @(posedge aclk) begin
        if (wr_en) begin
            mem[wr_addr] <= next_word;
        end
    end

endmodule : spc_array

/* File: spc_device.sv */
// SDRAM pin command interface, device side, with register bus
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
// Functional notes
// - Inputs sampled only on rising clock edge
// - Chip select gates commands, not mask
// - Clock enable low freezes following cycle
// - Clock enable low in standby: power-down
// - Shared address pins: 12 row, 8 column
// - Bank select picks activate or access bank
// - Row strobe low latches row address
// - Column strobe low starts column access
// - Write strobe: write, precharge; data captured
// - Byte mask floats read output byte
// - Byte mask blocks write byte
// - One shared data bus, never both driving
// - Read latency 1-3, bursts 1-8, page
// - Sequential or interleaved burst ordering
// - Four banks of 1M 32-bit words
// - Mask: write latency 0, read 2
// - Precharge-all bit ignores bank select
module spc_device #(
    parameter int ROW_W = spc_pkg::ROW_BITS,
    parameter int COL_W = spc_pkg::COL_BITS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [spc_pkg::AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [spc_pkg::AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic clock_enable,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [spc_pkg::BANK_W-1:0] bank_select,
    input wire logic [ROW_W-1:0] addr_lines,
    input wire logic [spc_pkg::MASK_W-1:0] byte_mask,
    input wire logic [spc_pkg::DATA_W-1:0] data_lines_in,
    output logic [spc_pkg::DATA_W-1:0] data_lines_out,
    output logic [spc_pkg::MASK_W-1:0] data_lines_oe_n
);
    import spc_pkg::*;

    localparam int MEM_AW = BANK_W + ROW_W + COL_W;

    // Pin-side state
    logic cke_prev;
    logic active;
    logic power_down;
    logic [MODE_W-1:0] mode;
    logic [BANKS-1:0] row_open;
    logic [ROW_W-1:0] open_row [BANKS];
    logic burst_on;
    logic burst_wr;
    logic burst_ap;
    logic [BANK_W-1:0] burst_bank;
    logic [COL_W-1:0] burst_base;
    logic [COL_W-1:0] burst_cnt;
    logic [COL_W-1:0] burst_last;
    logic [MASK_W-1:0] mask_d1;
    logic pipe1_v;
    logic pipe2_v;
    logic [DATA_W-1:0] pipe1_d;
    logic [DATA_W-1:0] pipe2_d;

    // Combinational decode, with lane_mask registered from len_m1
    spc_cmd_type cmd;
    logic [COL_W-1:0] len_m1;
    logic [COL_W-1:0] lane_mask;
    logic acc_valid;
    logic acc_wr;
    logic acc_start;
    logic [BANK_W-1:0] acc_bank;
    logic [COL_W-1:0] acc_col;
    logic acc_last;
    logic [MEM_AW-1:0] acc_addr;
    logic [DATA_W-1:0] rd_word;
    logic sel_v;
    logic [DATA_W-1:0] sel_d;

    // Register bus state
    logic [AXI_AW-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic reg_wr_fire;
    logic [31:0] status_word;

    // Strobes to command; only a selected chip sees them
    function automatic spc_cmd_type decode(input logic cs_n,
                                           input logic [2:0] strobes);
        spc_cmd_type c;
        c = CMD_NOP;
        if (!cs_n) begin
            unique case (strobes)
                3'h0: c = CMD_MODE_LOAD;
                3'h1: c = CMD_REFRESH;
                3'h2: c = CMD_PRECHARGE;
                3'h3: c = CMD_ACTIVATE;
                3'h4: c = CMD_WRITE;
                3'h5: c = CMD_READ;
                3'h6: c = CMD_BURST_STOP;
                3'h7: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction : decode

    // Column within a burst: wrap inside the burst window
    function automatic logic [COL_W-1:0] burst_col(
        input logic [COL_W-1:0] base, input logic [COL_W-1:0] k,
        input logic [COL_W-1:0] lm, input logic interleave);
        logic [COL_W-1:0] low;
        low = interleave ? (base ^ k) : COL_W'(base + k);
        return (base & ~lm) | (low & lm);
    endfunction : burst_col

    // Frozen whenever clock enable was low at the previous edge
    assign active = cke_prev;
    assign cmd = decode(chip_select_n,
        {row_strobe_n, col_strobe_n, write_strobe_n});

    // Burst length from the mode register
    always_comb begin
        unique case (mode[MODE_BL_LSB +: 3])
            BL_CODE_2: len_m1 = COL_W'(1);
            BL_CODE_4: len_m1 = COL_W'(3);
            BL_CODE_8: len_m1 = COL_W'(7);
            BL_CODE_FULL: len_m1 = mode[MODE_BT_BIT] ? '0 : '1;
            default: len_m1 = '0;
        endcase
    end

    // Access for this edge: new column command or burst continuation
    always_comb begin
        acc_start = active && (cmd == CMD_READ || cmd == CMD_WRITE);
        acc_valid = acc_start || (active && burst_on);
        acc_wr = acc_start ? (cmd == CMD_WRITE) : burst_wr;
        acc_bank = acc_start ? bank_select : burst_bank;
        acc_col = acc_start ? addr_lines[COL_W-1:0] :
            burst_col(burst_base, burst_cnt, lane_mask,
                      mode[MODE_BT_BIT]);
        acc_last = acc_start ? (len_m1 == '0 ||
            (cmd == CMD_WRITE && mode[MODE_WBL_BIT])) :
            (burst_cnt == burst_last);
        acc_addr = {acc_bank, open_row[acc_bank], acc_col};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lane_mask <= '0;
        end else begin
            lane_mask <= len_m1;
        end
    end

    // Clock enable history and power-down status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cke_prev <= 1'b0;
            power_down <= 1'b0;
        end else begin
            cke_prev <= clock_enable;
            // Standby with clock enable low sets the power-down status bit
            power_down <= !clock_enable &&
                (power_down || (!burst_on && active));
        end
    end

    // Row state per bank
    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        logic hit;
        logic close;
        assign hit = (bank_select == BANK_W'(b));
        assign close = (cmd == CMD_PRECHARGE &&
            (addr_lines[PALL_BIT] || hit)) ||
            (acc_valid && acc_last && burst_ap && !acc_start &&
             burst_bank == BANK_W'(b));
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                row_open[b] <= 1'b0;
                open_row[b] <= '0;
            end else if (active) begin
                if (cmd == CMD_ACTIVATE && hit) begin
                    row_open[b] <= 1'b1;
                    open_row[b] <= addr_lines;
                end else if (close) begin
                    row_open[b] <= 1'b0;
                end
            end
        end
    end

    // Burst sequencer; a new column command cuts the old burst
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            burst_on <= 1'b0;
            burst_wr <= 1'b0;
            burst_ap <= 1'b0;
            burst_bank <= '0;
            burst_base <= '0;
            burst_cnt <= '0;
            burst_last <= '0;
        end else if (active) begin
            if (acc_start) begin
                burst_on <= !acc_last;
                burst_wr <= (cmd == CMD_WRITE);
                burst_ap <= addr_lines[PALL_BIT];
                burst_bank <= bank_select;
                burst_base <= addr_lines[COL_W-1:0];
                burst_cnt <= COL_W'(1);
                burst_last <= len_m1;
            end else if (cmd == CMD_BURST_STOP ||
                         (cmd == CMD_PRECHARGE &&
                          (addr_lines[PALL_BIT] ||
                           bank_select == burst_bank))) begin
                burst_on <= 1'b0;
            end else if (burst_on) begin
                burst_on <= !acc_last;
                burst_cnt <= COL_W'(burst_cnt + 1'b1);
            end
        end
    end

    // Storage; write data and mask are taken at the same edge
    spc_array #(
        .ADDR_W(MEM_AW),
        .DATA_W(DATA_W),
        .MASK_W(MASK_W)
    ) u_array (
        .aclk(aclk),
        .wr_en(acc_valid && acc_wr),
        .wr_addr(acc_addr),
        .wr_data(data_lines_in),
        .wr_block(byte_mask),
        .rd_addr(acc_addr),
        .rd_data(rd_word)
    );

    // Read latency pipe; reserved latency codes behave as three
    always_comb begin
        unique case (mode[MODE_CL_LSB +: 3])
            CL_CODE_1: begin
                sel_v = acc_valid && !acc_wr;
                sel_d = rd_word;
            end
            CL_CODE_2: begin
                sel_v = pipe1_v;
                sel_d = pipe1_d;
            end
            default: begin
                sel_v = pipe2_v;
                sel_d = pipe2_d;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pipe1_v <= 1'b0;
            pipe2_v <= 1'b0;
            pipe1_d <= '0;
            pipe2_d <= '0;
        end else if (active) begin
            pipe1_v <= acc_valid && !acc_wr;
            pipe1_d <= rd_word;
            pipe2_v <= pipe1_v;
            pipe2_d <= pipe1_d;
        end
    end

    // Output drivers; mask sampled two edges earlier floats the lane
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_d1 <= '0;
            data_lines_out <= '0;
            data_lines_oe_n <= '1;
        end else if (active) begin
            mask_d1 <= byte_mask;
            data_lines_out <= sel_d;
            // Drive only while read data is due and the lane is unmasked
            data_lines_oe_n <= {MASK_W{!sel_v}} | mask_d1;
        end
    end

    // Mode register: pin load wins over a bus write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= MODE_RESET;
        end else if (active && cmd == CMD_MODE_LOAD) begin
            mode <= addr_lines[MODE_W-1:0];
        end else if (reg_wr_fire && aw_addr_q == REG_MODE_OFF) begin
            if (w_strb_q[0]) begin
                mode[7:0] <= w_data_q[7:0];
            end
            if (w_strb_q[1]) begin
                mode[MODE_W-1:8] <= w_data_q[MODE_W-1:8];
            end
        end
    end

    assign status_word = {24'h000000, burst_wr, burst_on, !cke_prev,
                          power_down, row_open};

    // Write address and data channels, taken in either order
    assign reg_wr_fire = !awready && !wready && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            aw_addr_q <= '0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_addr_q <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b1;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    // Write response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (reg_wr_fire) begin
            bvalid <= 1'b1;
            bresp <= (aw_addr_q == REG_MODE_OFF ||
                      aw_addr_q == REG_STATUS_OFF) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read channel; data answers the cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            if (araddr == REG_MODE_OFF) begin
                rdata <= {{(32-MODE_W){1'b0}}, mode};
                rresp <= RESP_OKAY;
            end else if (araddr == REG_STATUS_OFF) begin
                rdata <= status_word;
                rresp <= RESP_OKAY;
            end else begin
                rdata <= '0;
                rresp <= RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

endmodule : spc_device

/* File: spc_device_asserts.sv */
// Port checks for the pin command device and its register bus
`timescale 1ns/10ps
module spc_device_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic clock_enable,
    input wire logic [spc_pkg::MASK_W-1:0] byte_mask,
    input wire logic [spc_pkg::DATA_W-1:0] data_lines_out,
    input wire logic [spc_pkg::MASK_W-1:0] data_lines_oe_n
);
    import spc_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Both halves of a write accepted at one edge
    sequence wr_take_s;
        awvalid && awready && wvalid && wready;
    endsequence
    // Clock enable seen low, then the edge that it freezes
    sequence cke_low_s;
        !clock_enable ##1 1'b1;
    endsequence
    // Mask seen while the clock runs; $past guards the reset edge
    sequence rd_mask_s;
        $past(aresetn) && $past(clock_enable) && clock_enable
            && byte_mask != 4'h0 ##1 clock_enable;
    endsequence
    rst_idle_a: assert property ($rose(aresetn) |-> awready && wready
        && arready && !bvalid && !rvalid && data_lines_oe_n == 4'hf)
        else $error("bus or lanes not idle after reset");
    b_resp_a: assert property (wr_take_s |=> !awready && !wready ##1 bvalid)
        else $error("write response late or slots not closed");
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before accepted");
    b_done_a: assert property (bvalid && bready |=> !bvalid && awready
        && wready) else $error("write slots not reopened");
    r_resp_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer not one cycle after address");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data changed before accepted");
    frz_out_a: assert property (cke_low_s |=> $stable(data_lines_oe_n)
        && $stable(data_lines_out)) else $error("lanes moved while frozen");
    mask_rd_a: assert property (rd_mask_s |=>
        (data_lines_oe_n & $past(byte_mask, 2)) == $past(byte_mask, 2))
        else $error("masked lane driven two cycles after mask");
endmodule : spc_device_asserts

bind spc_device spc_device_asserts i_chk (
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp,
    .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
    .clock_enable, .byte_mask, .data_lines_out, .data_lines_oe_n
);

/* File: spc_ctrl_model.sv */
// Memory controller model driving the pin side of the device
`timescale 1ns/10ps
module spc_ctrl_model (
    input wire logic aclk,
    output logic clock_enable,
    output logic chip_select_n,
    output logic row_strobe_n,
    output logic col_strobe_n,
    output logic write_strobe_n,
    output logic [spc_pkg::BANK_W-1:0] bank_select,
    output logic [spc_pkg::ROW_BITS-1:0] addr_lines,
    output logic [spc_pkg::MASK_W-1:0] byte_mask,
    output logic [spc_pkg::DATA_W-1:0] data_lines_in,
    input wire logic [spc_pkg::DATA_W-1:0] data_lines_out,
    input wire logic [spc_pkg::MASK_W-1:0] data_lines_oe_n
);
    import spc_pkg::*;
    logic drive_on;
    logic [DATA_W-1:0] drive_data;
    logic [DATA_W-1:0] held_data;
    // Power-up: clock running, no command, mask high
    initial begin
        {chip_select_n, row_strobe_n, col_strobe_n, write_strobe_n} = 4'h7;
        clock_enable = 1'b1;
        bank_select = 2'h0;
        addr_lines = 12'h000;
        byte_mask = 4'hf;
        drive_on = 1'b0;
        drive_data = 32'h0;
        held_data = 32'h0;
    end
    // One command per cycle, changed just after the edge
    task automatic put(input logic [3:0] c, input logic [1:0] b = 2'h0,
        input logic [11:0] a = 12'h000, input logic [3:0] m = 4'h0,
        input logic [31:0] d = 32'h0, input logic dv = 1'b0,
        input logic ke = 1'b1);
        @(posedge aclk);
        {chip_select_n, row_strobe_n, col_strobe_n, write_strobe_n} <= c;
        bank_select <= b;
        addr_lines <= a;
        byte_mask <= m;
        drive_data <= d;
        drive_on <= dv;
        clock_enable <= ke;
    endtask : put
    // Last value we drove, so a released lane can show its inverse
    always @(posedge aclk) begin
        if (drive_on)
            held_data <= drive_data;
    end
    // Lane resolution; no pull, so a floating lane never looks stale
    always_comb begin
        for (int i = 0; i < MASK_W; i++)
            data_lines_in[i*8 +: 8] = !data_lines_oe_n[i] ?
                data_lines_out[i*8 +: 8] : drive_on ?
                drive_data[i*8 +: 8] : ~held_data[i*8 +: 8];
    end
endmodule : spc_ctrl_model

/* File: test_spc_device.sv */
// Self-checking bench for the pin command device and its register bus
`timescale 1ns/10ps
module test_spc_device;
    import spc_pkg::*;
    localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4;
    localparam logic [3:0] PRE = 4'h2, REF = 4'h1, MLD = 4'h0, DES = 4'hb;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [3:0] wstrb, byte_mask, data_lines_oe_n;
    logic [1:0] bresp, rresp, rr, bank_select;
    logic clock_enable, chip_select_n, row_strobe_n;
    logic col_strobe_n, write_strobe_n;
    logic [11:0] addr_lines;
    logic [31:0] data_lines_in, data_lines_out;
    int err_total, checks_done;

    spc_device i_dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .clock_enable,
        .chip_select_n, .row_strobe_n, .col_strobe_n, .write_strobe_n,
        .bank_select, .addr_lines, .byte_mask, .data_lines_in,
        .data_lines_out, .data_lines_oe_n
    );
    spc_ctrl_model i_ctrl (
        .aclk, .clock_enable, .chip_select_n, .row_strobe_n, .col_strobe_n,
        .write_strobe_n, .bank_select, .addr_lines, .byte_mask,
        .data_lines_in, .data_lines_out, .data_lines_oe_n
    );

    // 50 MHz clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic tally_and_finish;
        if (err_total == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask : chk

    // Write: address and data offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rr = bresp;
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask : axr

    task automatic st(input logic [31:0] e);
        axr(REG_STATUS_OFF);
        chk("status", e, rv);
    endtask : st

    // Hang guard, well past the longest expected run
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        tally_and_finish;
    end

    initial begin : main
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        err_total = 0;
        checks_done = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (10000) i_ctrl.put(NOP);
        i_ctrl.put(PRE, 2'h0, 12'h400);
        i_ctrl.put(REF);
        i_ctrl.put(REF);
        i_ctrl.put(NOP);
        axr(REG_MODE_OFF);
        chk("mode reset", 32'h030, rv);
        axr(8'h08);
        chk("unmapped rresp", 32'h2, {30'h0, rr});
        axw(8'h0c, 32'hffffffff);
        chk("unmapped bresp", 32'h2, {30'h0, rr});
        // Latency 2, burst 2, sequential
        axw(REG_MODE_OFF, 32'h021);
        axr(REG_MODE_OFF);
        chk("mode", 32'h021, rv);
        i_ctrl.put(ACT, 2'h1, 12'h005);
        i_ctrl.put(NOP);
        st(32'h2);
        // Two bursts to one column, the second with byte 0 blocked on its first beat
        i_ctrl.put(WR, 2'h1, 12'h004, 4'h0, 32'h11223344, 1'b1);
        i_ctrl.put(NOP, 2'h0, 12'h000, 4'h0, 32'h55667788, 1'b1);
        i_ctrl.put(WR, 2'h1, 12'h004, 4'h1, 32'ha1b2c3d4, 1'b1);
        i_ctrl.put(NOP, 2'h0, 12'h000, 4'h0, 32'he5f60718, 1'b1);
        i_ctrl.put(RD, 2'h1, 12'h304);
        i_ctrl.put(NOP, 2'h0, 12'h000, 4'h4);
        i_ctrl.put(NOP);
        #1;
        chk("word 4", 32'ha1b2c344, data_lines_out);
        chk("lanes 4", 32'h0, {28'h0, data_lines_oe_n});
        i_ctrl.put(NOP);
        #1;
        chk("word 5", 32'he5000718, data_lines_out & 32'hff00ffff);
        chk("lanes 5", 32'h4, {28'h0, data_lines_oe_n});
        // Every read latency, loaded over the pins
        for (int cl = 1; cl <= 3; cl++) begin
            i_ctrl.put(PRE, 2'h0, 12'h400);
            i_ctrl.put(MLD, 2'h0, 12'(cl * 16));
            i_ctrl.put(NOP);
            i_ctrl.put(NOP);
            i_ctrl.put(ACT, 2'h1, 12'h005);
            i_ctrl.put(RD, 2'h1, 12'h005);
            repeat (cl - 1) i_ctrl.put(NOP);
            #1;
            chk("early lanes", 32'hf, {28'h0, data_lines_oe_n});
            i_ctrl.put(NOP);
            #1;
            chk("latency word", 32'he5f60718, data_lines_out);
        end
        i_ctrl.put(DES, 2'h2, 12'h007);
        i_ctrl.put(NOP);
        st(32'h2);
        i_ctrl.put(ACT, 2'h2, 12'h007);
        i_ctrl.put(PRE, 2'h0, 12'h400);
        i_ctrl.put(NOP);
        st(32'h0);
        // Clock enable low, then a command too soon after raising it
        i_ctrl.put(NOP, 2'h0, 12'h0, 4'h0, 32'h0, 1'b0, 1'b0);
        i_ctrl.put(ACT, 2'h3, 12'h009, 4'h0, 32'h0, 1'b0, 1'b0);
        st(32'h30);
        i_ctrl.put(ACT, 2'h3, 12'h009);
        i_ctrl.put(NOP);
        st(32'h0);
        i_ctrl.put(ACT, 2'h3, 12'h009);
        i_ctrl.put(NOP);
        st(32'h8);
        // Interleaved burst of four, written from column 0x12, read from 0x10
        i_ctrl.put(PRE, 2'h0, 12'h400);
        i_ctrl.put(MLD, 2'h0, 12'h01a);
        i_ctrl.put(NOP);
        i_ctrl.put(NOP);
        i_ctrl.put(ACT, 2'h3, 12'h009);
        for (int k = 0; k < 4; k++) begin
            i_ctrl.put(k == 0 ? WR : NOP, 2'h3, 12'h012, 4'h0, 32'(k), 1'b1);
        end
        i_ctrl.put(RD, 2'h3, 12'h010);
        for (int k = 0; k < 4; k++) begin
            i_ctrl.put(NOP);
            #1;
            chk("interleave", 32'(k ^ 2), data_lines_out);
        end
        tally_and_finish;
    end
endmodule : test_spc_device
